// ---- hdl/bpm_ctrl.sv ----
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
module bpm_ctrl
  import bpm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins and comparator flags
  input  wire logic        storage_select_pin,
  input  wire logic        push_button_in,
  input  wire bpm_flags_t  flags_in,
  // power switches and indicators
  output logic             input_path_switch,
  output logic             converter_high_switch,
  output logic             converter_low_switch,
  output bpm_cur_t         charge_current_cmd,
  output logic             flashlight_drive,
  output logic             level_lamp_one,
  output logic             level_lamp_two,
  output logic             level_lamp_three,
  output logic             level_lamp_four
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SW = $bits(bpm_flags_t) + 2;
  // select and button rest high, so reset must not fake a press
  localparam logic [SW-1:0] SYNC_IDLE = {PIN_IDLE, {(SW-2){1'b0}}};
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  bpm_flags_t    fl;
  logic          sel_s;
  logic          pb_low;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end else begin
      sync_a <= {storage_select_pin, push_button_in, flags_in};
      sync_b <= sync_a;
    end
  end

  assign fl     = bpm_flags_t'(sync_b[SW-3:0]);
  assign sel_s  = sync_b[SW-1];
  assign pb_low = ~sync_b[SW-2];

  // ---------------------------------------------------------------
  // millisecond timebase
  // ---------------------------------------------------------------
  logic [15:0] tick_cnt;
  logic        ms;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      ms       <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      ms       <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      ms       <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [1:0]  ctrl;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  bpm_mode_t   mode;
  bpm_chg_t    chg;
  logic        hiccup;
  logic        take;

  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= take && hwrite;
      wr_addr   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take && !hwrite && haddr[7:0] == CTRL_ADDR) begin
        hrdata <= {30'h0, ctrl};
      end else if (take && !hwrite && haddr[7:0] == STATUS_ADDR) begin
        hrdata <= {12'h0, level_lamp_four, level_lamp_three, level_lamp_two,
                   level_lamp_one, flashlight_drive, hiccup, charge_current_cmd,
                   3'h0, chg, mode};
      end else begin
        hrdata <= '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_pend && wr_addr == CTRL_ADDR) begin
      ctrl <= hwdata[1:0];
    end
  end

  logic flash_var;
  logic alarm_var;
  assign flash_var = ctrl[CTRL_FLASH_BIT];
  assign alarm_var = ctrl[CTRL_ALARM_BIT];

  // ---------------------------------------------------------------
  // push button timing
  // ---------------------------------------------------------------
  logic [MS_W-1:0] press_ms;
  logic [MS_W-1:0] disp_ms;
  logic            press_ok;
  logic            display_on;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      press_ms <= '0;
    end else if (!pb_low) begin
      press_ms <= '0;
    end else if (ms && press_ms != LIGHT_MS) begin
      press_ms <= press_ms + 13'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      press_ok <= 1'b0;
    end else begin
      press_ok <= pb_low && (press_ms > (flash_var ? PB_FLASH_MS : PB_BOOST_MS));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_ms <= '0;
    end else if (press_ok) begin
      disp_ms <= DISPLAY_MS;
    end else if (ms && disp_ms != '0) begin
      disp_ms <= disp_ms - 13'h0001;
    end
  end

  assign display_on = press_ok || disp_ms != '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flashlight_drive <= 1'b0;
    end else if (!flash_var) begin
      flashlight_drive <= 1'b0;
    end else if (pb_low && ms && press_ms == LIGHT_MS - 13'h0001) begin
      flashlight_drive <= ~flashlight_drive;
    end
  end

  // ---------------------------------------------------------------
  // mode selection
  // ---------------------------------------------------------------
  logic [MS_W-1:0] gap_ms;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode   <= MODE_HZ;
      gap_ms <= '0;
    end else begin
      case (mode)
        MODE_HZ: begin
          if (fl.input_supply_valid) begin
            mode <= MODE_CHARGE;
          end else if (!sel_s && press_ok) begin
            mode <= MODE_BOOST;
          end
        end
        MODE_BOOST: begin
          if (fl.input_supply_valid) begin
            mode   <= MODE_GAP;
            gap_ms <= '0;
          end else if (sel_s) begin
            mode <= MODE_HZ;
          end
        end
        MODE_CHARGE: begin
          if (!fl.input_supply_valid) begin
            mode   <= MODE_GAP;
            gap_ms <= '0;
          end
        end
        MODE_GAP: begin
          if (gap_ms == GAP_MS) begin
            mode <= MODE_HZ;
          end else if (ms) begin
            gap_ms <= gap_ms + 13'h0001;
          end
        end
        default: mode <= MODE_HZ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // input current limit hiccup
  // ---------------------------------------------------------------
  logic [MS_W-1:0] hic_ms;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hiccup <= 1'b0;
      hic_ms <= '0;
    end else if (mode != MODE_CHARGE) begin
      hiccup <= 1'b0;
      hic_ms <= '0;
    end else if (!hiccup && fl.out_at_uvp && fl.in_limit_active) begin
      hiccup <= 1'b1;
      hic_ms <= '0;
    end else if (hiccup && hic_ms == HICCUP_MS) begin
      hiccup <= 1'b0;
    end else if (hiccup && ms) begin
      hic_ms <= hic_ms + 13'h0001;
    end
  end

  // ---------------------------------------------------------------
  // charge sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg <= CHG_IDLE;
    end else if (mode != MODE_CHARGE) begin
      chg <= CHG_IDLE;
    end else begin
      case (chg)
        CHG_IDLE: chg <= CHG_PRE;
        CHG_PRE:  if (fl.above_precond) chg <= CHG_FAST;
        CHG_FAST: if (fl.at_term_voltage) chg <= CHG_TOP;
        CHG_TOP:  if (fl.below_eoc_current) chg <= CHG_EOC;
        CHG_EOC:  if (fl.below_recharge) chg <= CHG_FAST;
        default:  chg <= CHG_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power switches
  // ---------------------------------------------------------------
  logic conv_on;
  assign conv_on = mode == MODE_BOOST || (mode == MODE_CHARGE && chg != CHG_EOC
                   && chg != CHG_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_path_switch     <= 1'b0;
      converter_high_switch <= 1'b0;
      converter_low_switch  <= 1'b0;
      charge_current_cmd    <= CUR_OFF;
    end else begin
      input_path_switch     <= mode == MODE_CHARGE && !hiccup;
      converter_high_switch <= conv_on;
      converter_low_switch  <= conv_on;
      case (mode == MODE_CHARGE ? chg : CHG_IDLE)
        CHG_PRE:  charge_current_cmd <= CUR_PRE10;
        CHG_FAST: charge_current_cmd <= CUR_FAST;
        CHG_TOP:  charge_current_cmd <= CUR_CV;
        default:  charge_current_cmd <= CUR_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // level lamps
  // ---------------------------------------------------------------
  logic [MS_W-1:0] blink_ms;
  logic            blink;
  logic [3:0]      lvl;
  logic [3:0]      next_lamps;
  logic            charging;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_ms <= '0;
      blink    <= 1'b1;
    end else if (ms && blink_ms == BLINK_MS - 13'h0001) begin
      blink_ms <= '0;
      blink    <= ~blink;
    end else if (ms) begin
      blink_ms <= blink_ms + 13'h0001;
    end
  end

  assign charging = mode == MODE_CHARGE;
  // analog comparators already place the lower thresholds at fixed offsets
  assign lvl = (charging || mode == MODE_BOOST) ? fl.level_comp : fl.level_hz;

  for (genvar i = 0; i < 4; i++) begin : g_lamp
    logic solid;
    logic flash;
    if (i == 0) begin : g_first
      assign solid = charging ? lvl[0] : (fl.above_2v9 && lvl[0]);
      assign flash = charging ? !lvl[0] : (alarm_var && fl.above_2v9 && !lvl[0]);
    end else begin : g_rest
      assign solid = charging ? (i < 3 && lvl[i]) : (fl.above_2v9 && lvl[i]);
      assign flash = charging && lvl[i-1] && (i == 3 || !lvl[i]);
    end
    assign next_lamps[i] = (charging && chg == CHG_EOC) ? 1'b1 :
                           (!charging && !display_on) ? 1'b0 :
                           (solid || (flash && blink));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_lamp_one   <= 1'b0;
      level_lamp_two   <= 1'b0;
      level_lamp_three <= 1'b0;
      level_lamp_four  <= 1'b0;
    end else begin
      level_lamp_one   <= next_lamps[0];
      level_lamp_two   <= next_lamps[1];
      level_lamp_three <= next_lamps[2];
      level_lamp_four  <= next_lamps[3];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_GAP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_GAP && gap_ms < GAP_MS) |=> mode == MODE_GAP)
    else $error("gap left before 2 s");

  AST_GAP_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_GAP) [*2] |-> !input_path_switch && !converter_high_switch
                              && !converter_low_switch)
    else $error("switch on during gap");

  AST_VIN_LEAVES_BOOST: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_BOOST && fl.input_supply_valid) |=> mode == MODE_GAP)
    else $error("valid input did not leave boost");

  AST_SEL_HIGH_NO_BOOST: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_HZ && sel_s) |=> mode != MODE_BOOST)
    else $error("boost entered with select high");

  AST_HZ_SWITCHES: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(mode) == MODE_HZ |-> !converter_high_switch && !input_path_switch
    && !converter_low_switch)
    else $error("switch on in high impedance");

  AST_PRE_CURRENT: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_CHARGE && chg == CHG_PRE) |=> charge_current_cmd == CUR_PRE10)
    else $error("precondition current wrong");

  AST_PRE_TO_FAST: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_CHARGE && chg == CHG_PRE && fl.above_precond) |=> chg == CHG_FAST)
    else $error("precondition not left");

  AST_TOP_TO_EOC: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_CHARGE && chg == CHG_TOP && fl.below_eoc_current) |=> chg == CHG_EOC
    ##1 charge_current_cmd == CUR_OFF)
    else $error("top-off did not end");

  AST_RECHARGE: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_CHARGE && chg == CHG_EOC && fl.below_recharge) |=> chg == CHG_FAST)
    else $error("recharge missed");

  AST_HICCUP_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hiccup) |=> !input_path_switch)
    else $error("input switch on in hiccup");

  AST_EOC_LAMPS: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_CHARGE && chg == CHG_EOC) |=> level_lamp_one && level_lamp_two
    && level_lamp_three && level_lamp_four)
    else $error("lamps not solid at end of charge");

endmodule

// ---- hdl/bpm_pkg.sv ----
//
// Functional notes
// - Boost and charge swap only via a 2 s gap with all switches off.
// - A valid input supply always selects charge mode.
// - No input: select low gives boost, select high gives high impedance.
// - Plain variant: boost starts after button held low over 100 ms.
// - Flashlight variant: boost starts after button held low over 30 ms.
// - Flashlight variant: each 3 s press toggles the flashlight driver.
// - Output at 4.25 V while input limiting: input switch off, retry after 2 s.
// - Charge steps precondition, fast, top-off, end of charge in order.
// - Each entry to charge mode starts in precondition, leaves it above the precondition level.
// - Precondition current command is 10 % of fast current.
// - Fast charge is constant current until termination voltage, then top-off.
// - Top-off is constant voltage until current under 13 %, then end of charge.
// - End of charge stops charging but keeps watching battery voltage.
// - Battery 200 mV under end voltage restarts constant-current charging.
// - Charging: lamp above level band flashes, lower lamps solid; lamp one lowest.
// - End of charge: no flashing, all four lamps solid.
// - Display mode: reached lamps solid; under 2.9 V dark; alarm variant flashes one.
// - Lower three lamp thresholds follow the top threshold at fixed offsets.
// - Charging or discharging uses impedance-compensated lamp thresholds.
// - Flashing lamps go 1 s on, 1 s off.
// - After push and release the display stays lit about 5 s.
// - High-impedance mode holds every power switch off.
package bpm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MS_W = 13;
  localparam logic [MS_W-1:0] GAP_MS      = 13'h07d0;  // 2000 ms
  localparam logic [MS_W-1:0] HICCUP_MS   = 13'h07d0;  // 2000 ms
  localparam logic [MS_W-1:0] PB_BOOST_MS = 13'h0064;  // 100 ms
  localparam logic [MS_W-1:0] PB_FLASH_MS = 13'h001e;  // 30 ms
  localparam logic [MS_W-1:0] LIGHT_MS    = 13'h0bb8;  // 3000 ms
  localparam logic [MS_W-1:0] BLINK_MS    = 13'h03e8;  // 1000 ms
  localparam logic [MS_W-1:0] DISPLAY_MS  = 13'h1388;  // 5000 ms

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int CTRL_FLASH_BIT = 0;
  localparam int CTRL_ALARM_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] PIN_IDLE   = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_HZ     = 4'h1,
    MODE_GAP    = 4'h2,
    MODE_BOOST  = 4'h4,
    MODE_CHARGE = 4'h8
  } bpm_mode_t;

  typedef enum logic [4:0] {
    CHG_IDLE = 5'h01,
    CHG_PRE  = 5'h02,
    CHG_FAST = 5'h04,
    CHG_TOP  = 5'h08,
    CHG_EOC  = 5'h10
  } bpm_chg_t;

  typedef enum logic [1:0] {
    CUR_OFF   = 2'h0,
    CUR_PRE10 = 2'h1,
    CUR_FAST  = 2'h2,
    CUR_CV    = 2'h3
  } bpm_cur_t;

  typedef struct packed {
    logic       input_supply_valid;
    logic       out_at_uvp;
    logic       in_limit_active;
    logic       above_precond;
    logic       at_term_voltage;
    logic       below_eoc_current;
    logic       below_recharge;
    logic       above_2v9;
    logic [3:0] level_hz;
    logic [3:0] level_comp;
  } bpm_flags_t;

endpackage

// ---- testbench/bpm_far_side.sv ----
`timescale 1ns/100ps
module bpm_far_side
  import bpm_pkg::*;
#(
  parameter int PRE_MV  = 3000,
  parameter int TERM_MV = 4200,
  parameter int COMP_MV = 100
) (
  // clock
  input  wire logic  hclk,
  // pins toward the block
  output logic       push_button_in,
  output bpm_flags_t flags_in,
  // switch seen from the block
  input  wire logic  input_path_switch
);
  // ---------------------------------------------------------------
  // battery, supply and button state set by the bench
  // ---------------------------------------------------------------
  localparam logic [3:0][15:0] LAMP_MV = {16'd4000, 16'd3750, 16'd3600, 16'd3350};
  int   vbat_mv  = 3700;
  int   cur_pct  = 100;
  logic vin_ok   = 1'b0;
  logic pressed  = 1'b0;
  logic overload = 1'b0;

  initial begin
    push_button_in = 1'b1;
    flags_in       = '0;
  end

  // comparators follow the analog state once a clock
  always @(posedge hclk) begin
    push_button_in               <= !pressed;
    flags_in.input_supply_valid  <= vin_ok;
    flags_in.in_limit_active     <= overload & input_path_switch;
    flags_in.out_at_uvp          <= overload & input_path_switch;
    flags_in.above_precond       <= vbat_mv > PRE_MV;
    flags_in.at_term_voltage     <= vbat_mv >= TERM_MV;
    flags_in.below_eoc_current   <= cur_pct < 13;
    flags_in.below_recharge      <= vbat_mv < TERM_MV - 200;
    flags_in.above_2v9           <= vbat_mv >= 2900;
    for (int i = 0; i < 4; i++) begin
      flags_in.level_hz[i]   <= vbat_mv >= LAMP_MV[i];
      flags_in.level_comp[i] <= vbat_mv >= LAMP_MV[i] + COMP_MV;
    end
  end
endmodule

// ---- testbench/test_battery_pack_mode_charge_control.sv ----
`timescale 1ns/100ps
module test_battery_pack_mode_charge_control;
  import bpm_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int TK = 2;
  localparam logic [31:0] A_CTRL = {24'h0, CTRL_ADDR};
  localparam logic [31:0] A_STAT = {24'h0, STATUS_ADDR};
  typedef struct packed {
    logic      sel;
    logic      input_supply;
    logic [1:0] ctrl;
    int        ms;
    bpm_mode_t mode;
    logic [2:0] sw;
  } bpm_row_t;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        sel_pin = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, in_sw, hi_sw, lo_sw, fld, pb;
  logic [3:0]  lamp;
  bpm_cur_t    cmd;
  bpm_flags_t  flags;
  logic [7:0]  obs;
  logic [31:0] d;
  int          cyc, el, el2, n_errors, comparisons;
  bpm_row_t    rows [10] = '{
    '{1'b1, 1'b0, 2'h0, 200, MODE_HZ, 3'h0},
    '{1'b0, 1'b0, 2'h0, 0, MODE_HZ, 3'h0},
    '{1'b0, 1'b0, 2'h0, 60, MODE_HZ, 3'h0},
    '{1'b0, 1'b0, 2'h0, 110, MODE_BOOST, 3'h3},
    '{1'b1, 1'b0, 2'h0, 0, MODE_HZ, 3'h0},
    '{1'b0, 1'b0, 2'h1, 20, MODE_HZ, 3'h0},
    '{1'b0, 1'b0, 2'h1, 40, MODE_BOOST, 3'h3},
    '{1'b1, 1'b0, 2'h1, 0, MODE_HZ, 3'h0},
    '{1'b1, 1'b1, 2'h0, 0, MODE_CHARGE, 3'h0},
    '{1'b1, 1'b0, 2'h0, 0, MODE_GAP, 3'h0}};
  assign obs = {fld, lo_sw, hi_sw, in_sw, lamp};

  always #20 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  bpm_far_side u_far (.hclk(hclk), .push_button_in(pb), .flags_in(flags),
                      .input_path_switch(in_sw));
  bpm_ctrl #(.TICK_CYCLES(TK)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .storage_select_pin(sel_pin), .push_button_in(pb), .flags_in(flags),
    .input_path_switch(in_sw), .converter_high_switch(hi_sw),
    .converter_low_switch(lo_sw), .charge_current_cmd(cmd), .flashlight_drive(fld),
    .level_lamp_one(lamp[0]), .level_lamp_two(lamp[1]), .level_lamp_three(lamp[2]),
    .level_lamp_four(lamp[3]));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic fail_out(input string nm);
    n_errors++;
    $display("Error %s expected done seen timeout", nm);
    wrap_up();
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) fail_out("ahb_addr");
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (hreadyout !== 1'b1) fail_out("ahb_ready");
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_st(input string nm, input logic [31:0] m, input logic [31:0] v,
                         input int ms, output int e);
    int t0;
    t0 = cyc;
    do begin
      ahb(1'b0, A_STAT, 32'h0, d);
      e = cyc - t0;
    end while ((d & m) !== v && e < ms * TK);
    comparisons++;
    if ((d & m) !== v) fail_out(nm);
  endtask

  task automatic wait_pin(input string nm, input int i, input logic v, input int ms,
                          output int e);
    int t0;
    t0 = cyc;
    while (obs[i] !== v && cyc - t0 < ms * TK) @(posedge hclk);
    e = cyc - t0;
    comparisons++;
    if (obs[i] !== v) fail_out(nm);
  endtask

  task automatic chk_dur(input string nm, input int e, input int ms);
    chk(nm, {31'h0, e >= (ms - 1) * TK && e <= (ms + 2) * TK + 8}, 32'h1);
  endtask

  task automatic count_tog(input string nm, input int i, input int ms, input int exp);
    int n;
    int e;
    logic p;
    wait_pin(nm, i, ~obs[i], 1100, e);
    p = obs[i];
    n = 0;
    repeat (ms * TK) begin
      @(posedge hclk);
      if (obs[i] !== p) n++;
      p = obs[i];
    end
    chk(nm, 32'(n), 32'(exp));
  endtask

  task automatic press(input int ms);
    if (ms > 0) begin
      @(posedge hclk);
      u_far.pressed <= 1'b1;
      repeat (ms * TK) @(posedge hclk);
      u_far.pressed <= 1'b0;
    end
  endtask

  task automatic pins(input logic s, input logic v);
    @(posedge hclk);
    sel_pin      <= s;
    u_far.vin_ok <= v;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge hclk);
    chk("reset_outs", {21'h0, obs, cmd, hreadyout}, 32'h1);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, A_CTRL, 32'h0, d);
    chk("ctrl_reset", d, {30'h0, CTRL_RESET});
    ahb(1'b0, A_STAT, 32'h0, d);
    chk("status_reset", d, 32'h11);
    ahb(1'b1, 32'h8, 32'hffffffff, d);
    ahb(1'b0, 32'h8, 32'h0, d);
    chk("unmapped", d, 32'h0);
    ahb(1'b1, A_CTRL, 32'h3, d);
    ahb(1'b0, A_CTRL, 32'h0, d);
    chk("ctrl_rw", d, 32'h3);
    for (int i = 0; i < 10; i++) begin
      ahb(1'b1, A_CTRL, {30'h0, rows[i].ctrl}, d);
      pins(rows[i].sel, rows[i].input_supply);
      press(rows[i].ms);
      repeat (20 * TK) @(posedge hclk);
      ahb(1'b0, A_STAT, 32'h0, d);
      chk("row_mode", d & 32'hf, {28'h0, rows[i].mode});
      if (rows[i].mode != MODE_CHARGE)
        chk("row_switch", {29'h0, in_sw, hi_sw, lo_sw}, {29'h0, rows[i].sw});
    end
    wait_st("gap_exit", 32'hf, 32'h1, 2100, el);
    pins(1'b0, 1'b0);
    press(110);
    wait_st("boost", 32'hf, 32'h4, 20, el);
    pins(1'b0, 1'b1);
    wait_st("gap_entry", 32'hf, 32'h2, 20, el);
    chk("gap_switch", {29'h0, in_sw, hi_sw, lo_sw}, 32'h0);
    @(posedge hclk);
    u_far.vbat_mv <= 2800;
    wait_st("gap_charge", 32'hf, 32'h8, 2100, el2);
    chk_dur("gap_time", el + el2 + 1, 2000);
    wait_st("precond", 32'h1f0, 32'h20, 20, el);
    chk("pre_cmd", {30'h0, cmd}, {30'h0, CUR_PRE10});
    chk("pre_lamps", {29'h0, lamp[3:1]}, 32'h0);
    count_tog("lamp1_flash", 0, 1500, 1);
    @(posedge hclk);
    u_far.vbat_mv <= 3700;
    wait_st("fast", 32'h1f0, 32'h40, 20, el);
    chk("fast_cmd", {30'h0, cmd}, {30'h0, CUR_FAST});
    chk("fast_lamps", {28'h0, lamp[3], 1'b0, lamp[1:0]}, 32'h3);
    count_tog("lamp3_flash", 2, 3500, 3);
    @(posedge hclk);
    u_far.vbat_mv <= 4250;
    wait_st("top", 32'h1f0, 32'h80, 20, el);
    chk("top_cmd", {30'h0, cmd}, {30'h0, CUR_CV});
    @(posedge hclk);
    u_far.cur_pct <= 10;
    wait_st("eoc", 32'h1f0, 32'h100, 20, el);
    chk("eoc_cmd", {30'h0, cmd}, {30'h0, CUR_OFF});
    repeat (1500 * TK) @(posedge hclk);
    chk("eoc_lamps", {28'h0, lamp}, 32'hf);
    @(posedge hclk);
    u_far.vbat_mv <= 3990;
    u_far.cur_pct <= 100;
    wait_st("recharge", 32'h1f0, 32'h40, 20, el);
    wait_pin("in_on", 4, 1'b1, 20, el);
    @(posedge hclk);
    u_far.overload <= 1'b1;
    wait_pin("hic_off", 4, 1'b0, 20, el);
    u_far.overload <= 1'b0;
    wait_pin("hic_on", 4, 1'b1, 2100, el);
    chk_dur("hic_time", el, 2000);
    pins(1'b0, 1'b0);
    wait_st("chg_exit", 32'hf, 32'h2, 20, el);
    chk("exit_switch", {29'h0, in_sw, hi_sw, lo_sw}, 32'h0);
    wait_st("exit_hz", 32'hf, 32'h1, 2100, el);
    ahb(1'b1, A_CTRL, 32'h1, d);
    @(posedge hclk);
    u_far.pressed <= 1'b1;
    wait_pin("light_on", 7, 1'b1, 3100, el);
    chk_dur("light_on_t", el, 3000);
    ahb(1'b0, A_STAT, 32'h0, d);
    chk("light_boost", d & 32'hf, 32'h4);
    u_far.pressed <= 1'b0;
    repeat (10 * TK) @(posedge hclk);
    chk("disp_lamps", {28'h0, lamp}, 32'h7);
    wait_pin("disp_off", 0, 1'b0, 5200, el);
    chk_dur("disp_time", el + 10 * TK, 5000);
    @(posedge hclk);
    u_far.pressed <= 1'b1;
    wait_pin("light_off", 7, 1'b0, 3100, el);
    chk_dur("light_off_t", el, 3000);
    u_far.pressed <= 1'b0;
    ahb(1'b1, A_CTRL, 32'h2, d);
    @(posedge hclk);
    u_far.vbat_mv <= 3300;
    press(110);
    count_tog("alarm_flash", 0, 1500, 1);
    chk("alarm_rest", {28'h0, lamp[3:1], 1'b0}, 32'h0);
    @(posedge hclk);
    u_far.vbat_mv <= 2800;
    repeat (20 * TK) @(posedge hclk);
    chk("dark_lamps", {28'h0, lamp}, 32'h0);
    wrap_up();
  end
endmodule
